// ===== pkg/adcsq_pkg.sv
// Constants, register map and state encodings for the ADC sequencer control.
// Assumes a single 200 MHz core clock and an SFR-style register port.
package adcsq_pkg;
	localparam logic [7:0] ADCSQ_TRACK_CFG_ADDR  = 8'hba;
	localparam logic [7:0] ADCSQ_LIMIT_FLAGS_ADDR = 8'hc7;
	localparam logic [7:0] ADCSQ_CONTROL_ADDR    = 8'he8;
	localparam logic [7:0] ADCSQ_SAR_CFG_ADDR    = 8'hbc;
	localparam logic [7:0] ADCSQ_POINTER_ADDR    = 8'hc3;
	localparam logic [7:0] ADCSQ_WINDOW_ADDR     = 8'hc4;
	localparam logic [7:0] ADCSQ_TS01_IADDR      = 8'h00;
	localparam logic [7:0] ADCSQ_TS67_IADDR      = 8'h03;
	localparam logic [7:0] ADCSQ_TEMP_LTL_IADDR  = 8'h3f;
	localparam logic [7:0] ADCSQ_TRACK_CFG_RESET = 8'hff;
	localparam logic [7:0] ADCSQ_SAR_CFG_RESET   = 8'hf8;
	localparam logic [7:0] ADCSQ_ZERO_RESET      = 8'h00;
	localparam int ADCSQ_CTRL_EN_BIT    = 7;
	localparam int ADCSQ_CTRL_BURST_BIT = 6;
	localparam int ADCSQ_PWR_LSB  = 4;
	localparam int ADCSQ_TM_LSB   = 2;
	localparam int ADCSQ_TK_LSB   = 0;
	localparam int ADCSQ_SC_LSB   = 3;
	localparam int ADCSQ_CLK_MHZ  = 200;
	localparam int ADCSQ_PWR_UNIT_NS = 200;
	localparam logic [7:0] ADCSQ_PWR_UNIT_CYC = 8'(ADCSQ_PWR_UNIT_NS * ADCSQ_CLK_MHZ / 1000);
	localparam logic [4:0] ADCSQ_CONV_SAR_CYC = 5'h0d;
	localparam logic [1:0] ADCSQ_EDGE_CORE_CYC = 2'h2;
	localparam logic [1:0] ADCSQ_TM_RESERVED = 2'h0;
	localparam logic [1:0] ADCSQ_TM_POST = 2'h1;
	localparam logic [1:0] ADCSQ_TM_PRE  = 2'h2;
	localparam logic [1:0] ADCSQ_TM_DUAL = 2'h3;
	typedef enum logic [2:0] {
		ADCSQ_IDLE   = 3'b000,
		ADCSQ_POWER  = 3'b001,
		ADCSQ_START  = 3'b010,
		ADCSQ_TRACK  = 3'b011,
		ADCSQ_CONV   = 3'b100,
		ADCSQ_FINISH = 3'b101
	} adcsq_state_t;
endpackage : adcsq_pkg

// ===== verilog/adcsq_limit.sv
// One channel limit comparator with its result flag.
// Assumes the limits are held stable while a result is being checked.
`timescale 1ns/1ps
`default_nettype none
module adcsq_limit
	import adcsq_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        check,
	input  wire logic [11:0] result,
	input  wire logic [11:0] high_limit,
	input  wire logic [11:0] low_limit,
	output logic             flag
);
	logic flag_reg;
	logic flag_next;
	logic hit;
	always_comb begin
		if (low_limit > high_limit) begin
			hit = (result > high_limit) && (result < low_limit);
		end else begin
			hit = (result < low_limit) || (result > high_limit);
		end
		flag_next = check ? hit : flag_reg;
	end
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end
	assign flag = flag_reg;
endmodule : adcsq_limit
`default_nettype wire

// ===== verilog/adcsq_top.sv
// Sequencer control: SFR port, indirect space, power, tracking and conversion timing.
// Assumes single-cycle SFR reads and writes and an external SAR data path.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top
	import adcsq_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  sfr_addr,
	input  wire logic        sfr_wr,
	input  wire logic        sfr_rd,
	input  wire logic [7:0]  sfr_wdata,
	output logic      [7:0]  sfr_rdata,
	output logic             sfr_hit,
	input  wire logic        start_conv,
	input  wire logic [11:0] sar_result,
	input  wire logic [2:0]  result_channel,
	input  wire logic        result_valid,
	input  wire logic [95:0] high_limits,
	input  wire logic [95:0] low_limits,
	input  wire logic [2:0]  slot_index,
	output logic      [3:0]  analog_input_mux,
	output logic      [7:0]  limit_flags,
	output logic             adc_powered,
	output logic             tracking,
	output logic             converting,
	output logic             sar_clk_tick,
	output logic             conv_done,
	output logic      [1:0]  tracking_mode_sel,
	output logic             mode_reserved,
	output logic      [7:0]  temp_low_limit_lo
);
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl_next;
	logic [7:0] track_reg;
	logic [7:0] track_next;
	logic [7:0] sarcfg_reg;
	logic [7:0] sarcfg_next;
	logic [7:0] pointer_reg;
	logic [7:0] pointer_next;
	logic [7:0] slot_reg [0:3];
	logic [7:0] slot_next [0:3];
	logic [7:0] templ_reg;
	logic [7:0] templ_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	adcsq_state_t state_reg;
	adcsq_state_t state_next;
	logic [11:0] wait_reg;
	logic [11:0] wait_next;
	logic [4:0] sdiv_reg;
	logic [4:0] sdiv_next;
	logic [4:0] sar_cnt_reg;
	logic [4:0] sar_cnt_next;
	logic [4:0] post_sar_len;
	logic converter_enable_bit;
	logic burst_mode_on;
	logic [3:0] burst_powerup_delay;
	logic [1:0] post_track_len;
	logic [4:0] sar_div;
	logic sar_tick;
	logic window_sel;
	logic [7:0] ind_rdata;

	function automatic logic [3:0] slot_field(input logic [7:0] pair, input logic upper);
		slot_field = upper ? pair[7:4] : pair[3:0];
	endfunction : slot_field

	assign converter_enable_bit = ctrl_reg[ADCSQ_CTRL_EN_BIT];
	assign burst_mode_on        = ctrl_reg[ADCSQ_CTRL_BURST_BIT];
	assign burst_powerup_delay  = track_reg[ADCSQ_PWR_LSB +: 4];
	assign tracking_mode_sel    = track_reg[ADCSQ_TM_LSB +: 2];
	assign post_track_len       = track_reg[ADCSQ_TK_LSB +: 2];
	assign sar_div              = sarcfg_reg[ADCSQ_SC_LSB +: 5];
	assign mode_reserved        = (tracking_mode_sel == ADCSQ_TM_RESERVED);
	assign window_sel           = (sfr_addr == ADCSQ_WINDOW_ADDR);
	// A divider lowered below the running count ticks at once instead of wrapping.
	assign sar_tick             = (sdiv_reg >= sar_div);
	assign post_sar_len         = 5'h02 << post_track_len;
	assign analog_input_mux     = slot_field(slot_reg[slot_index[2:1]], slot_index[0]);

	always_comb begin
		ind_rdata = 8'h00;
		if (pointer_reg <= ADCSQ_TS67_IADDR) begin
			ind_rdata = slot_reg[pointer_reg[1:0]];
		end else if (pointer_reg == ADCSQ_TEMP_LTL_IADDR) begin
			ind_rdata = templ_reg;
		end
	end

	always_comb begin
		ctrl_next    = ctrl_reg;
		track_next   = track_reg;
		sarcfg_next  = sarcfg_reg;
		pointer_next = pointer_reg;
		templ_next   = templ_reg;
		rdata_next   = rdata_reg;
		for (int i = 0; i < 4; i++) begin
			slot_next[i] = slot_reg[i];
		end
		if (sfr_wr) begin
			unique case (sfr_addr)
				ADCSQ_CONTROL_ADDR:   ctrl_next = sfr_wdata & 8'hc7;
				ADCSQ_TRACK_CFG_ADDR: track_next = sfr_wdata;
				ADCSQ_SAR_CFG_ADDR:   sarcfg_next = sfr_wdata & 8'hfe;
				ADCSQ_POINTER_ADDR:   pointer_next = sfr_wdata;
				ADCSQ_WINDOW_ADDR: begin
					if (pointer_reg <= ADCSQ_TS67_IADDR) begin
						slot_next[pointer_reg[1:0]] = sfr_wdata;
					end else if (pointer_reg == ADCSQ_TEMP_LTL_IADDR) begin
						templ_next = sfr_wdata;
					end
				end
				default: ;
			endcase
		end
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADCSQ_CONTROL_ADDR:     rdata_next = ctrl_reg | {3'b000, converting, 4'h0};
				ADCSQ_TRACK_CFG_ADDR:   rdata_next = track_reg;
				ADCSQ_SAR_CFG_ADDR:     rdata_next = sarcfg_reg;
				ADCSQ_POINTER_ADDR:     rdata_next = pointer_reg;
				ADCSQ_LIMIT_FLAGS_ADDR: rdata_next = limit_flags;
				default:                rdata_next = window_sel ? ind_rdata : 8'h00;
			endcase
		end
	end

	always_comb begin
		state_next   = state_reg;
		wait_next    = wait_reg;
		sar_cnt_next = sar_cnt_reg;
		sdiv_next    = sar_tick ? 5'h00 : sdiv_reg + 5'h01;
		conv_done    = 1'b0;
		unique case (state_reg)
			ADCSQ_IDLE: begin
				if (start_conv && converter_enable_bit) begin
					state_next = ADCSQ_START;
					wait_next  = {10'h000, ADCSQ_EDGE_CORE_CYC};
				end else if (start_conv && burst_mode_on) begin
					state_next = ADCSQ_POWER;
					wait_next  = 12'((burst_powerup_delay + 12'h001) * ADCSQ_PWR_UNIT_CYC);
				end
			end
			ADCSQ_POWER: begin
				wait_next = wait_reg - 12'h001;
				if (wait_reg == 12'h001) begin
					state_next = ADCSQ_START;
					wait_next  = {10'h000, ADCSQ_EDGE_CORE_CYC};
				end
			end
			ADCSQ_START: begin
				wait_next = wait_reg - 12'h001;
				if (wait_reg == 12'h001) begin
					state_next   = ADCSQ_TRACK;
					sar_cnt_next = post_sar_len;
				end
			end
			ADCSQ_TRACK: begin
				if (sar_tick) begin
					sar_cnt_next = sar_cnt_reg - 5'h01;
					if (sar_cnt_reg == 5'h01) begin
						state_next   = ADCSQ_CONV;
						sar_cnt_next = ADCSQ_CONV_SAR_CYC;
					end
				end
			end
			ADCSQ_CONV: begin
				if (sar_tick) begin
					sar_cnt_next = sar_cnt_reg - 5'h01;
					if (sar_cnt_reg == 5'h01) begin
						state_next = ADCSQ_FINISH;
						wait_next  = {10'h000, ADCSQ_EDGE_CORE_CYC};
					end
				end
			end
			ADCSQ_FINISH: begin
				wait_next = wait_reg - 12'h001;
				if (wait_reg == 12'h001) begin
					state_next = ADCSQ_IDLE;
					conv_done  = 1'b1;
				end
			end
			default: state_next = ADCSQ_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg    <= ADCSQ_ZERO_RESET;
			track_reg   <= ADCSQ_TRACK_CFG_RESET;
			sarcfg_reg  <= ADCSQ_SAR_CFG_RESET;
			pointer_reg <= ADCSQ_ZERO_RESET;
			templ_reg   <= ADCSQ_ZERO_RESET;
			rdata_reg   <= ADCSQ_ZERO_RESET;
			for (int i = 0; i < 4; i++) begin
				slot_reg[i] <= ADCSQ_ZERO_RESET;
			end
			state_reg   <= ADCSQ_IDLE;
			wait_reg    <= 12'h000;
			sdiv_reg    <= 5'h00;
			sar_cnt_reg <= 5'h00;
		end else begin
			ctrl_reg    <= ctrl_next;
			track_reg   <= track_next;
			sarcfg_reg  <= sarcfg_next;
			pointer_reg <= pointer_next;
			templ_reg   <= templ_next;
			rdata_reg   <= rdata_next;
			for (int i = 0; i < 4; i++) begin
				slot_reg[i] <= slot_next[i];
			end
			state_reg   <= state_next;
			wait_reg    <= wait_next;
			sdiv_reg    <= sdiv_next;
			sar_cnt_reg <= sar_cnt_next;
		end
	end

	// Power is held while enabled; in burst sleep it is raised only for a conversion.
	assign adc_powered = converter_enable_bit || (burst_mode_on && state_reg != ADCSQ_IDLE);
	assign tracking    = (state_reg == ADCSQ_TRACK);
	assign converting  = (state_reg != ADCSQ_IDLE) && (state_reg != ADCSQ_POWER);
	assign sar_clk_tick = sar_tick;
	assign sfr_rdata   = rdata_reg;
	assign sfr_hit     = (sfr_addr == ADCSQ_CONTROL_ADDR) || (sfr_addr == ADCSQ_TRACK_CFG_ADDR)
		|| (sfr_addr == ADCSQ_SAR_CFG_ADDR) || (sfr_addr == ADCSQ_POINTER_ADDR)
		|| window_sel || (sfr_addr == ADCSQ_LIMIT_FLAGS_ADDR);
	assign temp_low_limit_lo = templ_reg;

	for (genvar ch = 0; ch < 8; ch++) begin : g_limit
		adcsq_limit u_limit (
			.ref_clk    (ref_clk),
			.nrst       (nrst),
			.check      (result_valid && result_channel == 3'(ch)),
			.result     (sar_result),
			.high_limit (high_limits[ch*12 +: 12]),
			.low_limit  (low_limits[ch*12 +: 12]),
			.flag       (limit_flags[ch])
		);
	end
endmodule : adcsq_top
`default_nettype wire

// ===== bench/adcsq_chk.sv
// Port checker for the sequencer control top.
// Assumes it is bound to adcsq_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module adcsq_chk
	import adcsq_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        nrst,
	input wire logic [7:0]  sfr_addr,
	input wire logic        sfr_wr,
	input wire logic        sfr_rd,
	input wire logic [7:0]  sfr_wdata,
	input wire logic [7:0]  sfr_rdata,
	input wire logic        sfr_hit,
	input wire logic        start_conv,
	input wire logic [11:0] sar_result,
	input wire logic [2:0]  result_channel,
	input wire logic        result_valid,
	input wire logic [95:0] high_limits,
	input wire logic [95:0] low_limits,
	input wire logic [7:0]  limit_flags,
	input wire logic        adc_powered,
	input wire logic        tracking,
	input wire logic        converting,
	input wire logic        conv_done,
	input wire logic [1:0]  tracking_mode_sel,
	input wire logic [7:0]  temp_low_limit_lo
);
	logic        en_reg;
	logic        bu_reg;
	logic [7:0]  ptr_reg;
	logic [11:0] lt;
	logic [11:0] gt;
	logic        exp_f;
	// Mirrors the control bits and the indirect pointer from bus writes.
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			en_reg <= 1'b0;
			bu_reg <= 1'b0;
			ptr_reg <= 8'h00;
		end else if (sfr_wr && sfr_addr == ADCSQ_CONTROL_ADDR) begin
			en_reg <= sfr_wdata[7];
			bu_reg <= sfr_wdata[6];
		end else if (sfr_wr && sfr_addr == ADCSQ_POINTER_ADDR) begin
			ptr_reg <= sfr_wdata;
		end
	end
	assign lt = low_limits[result_channel*12 +: 12];
	assign gt = high_limits[result_channel*12 +: 12];
	assign exp_f = (lt > gt) ? (sar_result > gt && sar_result < lt) : (sar_result < lt || sar_result > gt);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_pwr; (!bu_reg || en_reg) |-> adc_powered == en_reg; endproperty
	a_pwr: assert property (p_pwr) else $error("power level wrong");
	property p_sleep; bu_reg && !en_reg && start_conv && !adc_powered |=> !converting; endproperty
	a_sleep: assert property (p_sleep) else $error("no power-up before conversion");
	property p_start; en_reg && start_conv && !converting |=> converting; endproperty
	a_start: assert property (p_start) else $error("start not taken");
	property p_done; conv_done |=> !converting && !conv_done; endproperty
	a_done: assert property (p_done) else $error("done not at end");
	property p_len; $fell(tracking) |-> converting [*8]; endproperty
	a_len: assert property (p_len) else $error("conversion too short");
	property p_tm; sfr_wr && sfr_addr == ADCSQ_TRACK_CFG_ADDR |=> tracking_mode_sel == $past(sfr_wdata[3:2]); endproperty
	a_tm: assert property (p_tm) else $error("tracking mode not stored");
	property p_rd0; sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00; endproperty
	a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
	property p_hold; !result_valid |=> $stable(limit_flags); endproperty
	a_hold: assert property (p_hold) else $error("flags moved without result");
	property p_flag; result_valid |=> limit_flags[$past(result_channel)] == $past(exp_f); endproperty
	a_flag: assert property (p_flag) else $error("limit flag wrong");
	property p_temp; sfr_wr && sfr_addr == ADCSQ_WINDOW_ADDR && ptr_reg == ADCSQ_TEMP_LTL_IADDR |=> temp_low_limit_lo == $past(sfr_wdata); endproperty
	a_temp: assert property (p_temp) else $error("temp limit not stored");
endmodule : adcsq_chk
bind adcsq_top adcsq_chk i_chk (.*);
`default_nettype wire

// ===== bench/adcsq_top_test.sv
// Self-checking bench for the sequencer control top.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module adcsq_top_test;
	import adcsq_pkg::*;
	logic        ref_clk = 1'b0, nrst = 1'b0, sfr_wr = 1'b0, sfr_rd = 1'b0;
	logic        start_conv = 1'b0, result_valid = 1'b0;
	logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, rv, sfr_rdata, limit_flags, temp_low_limit_lo;
	logic [11:0] sar_result = 12'h000;
	logic [2:0]  result_channel = 3'h0, slot_index = 3'h0;
	logic [95:0] high_limits = 96'h0, low_limits = 96'h0;
	logic [3:0]  analog_input_mux;
	logic [1:0]  tracking_mode_sel;
	logic        sfr_hit, adc_powered, tracking, converting, sar_clk_tick, conv_done, mode_reserved;
	int          err_total = 0, checked = 0, cyc = 0, trk, cv, lat, lat0;
	adcsq_top i_dut (.*);
	initial forever #2.5 ref_clk = ~ref_clk;
	task automatic end_sim;
		$display("Errors %0d, checks %0d", err_total, checked);
		if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic chn(input int g, input int e);
		checked++;
		if (g != e) begin
			err_total++;
			$display("Error at %0t: count %0d expected %0d", $time, g, e);
		end
	endtask : chn
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'b1;
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		sfr_addr <= a;
		sfr_rd <= 1'b1;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		#1 rv = sfr_rdata;
		chk(rv, e);
	endtask : rc
	task automatic res(input logic [2:0] c, input logic [11:0] v);
		@(posedge ref_clk);
		result_channel <= c;
		sar_result <= v;
		result_valid <= 1'b1;
		@(posedge ref_clk);
		result_valid <= 1'b0;
		#1;
	endtask : res
	task automatic conv;
		@(posedge ref_clk);
		start_conv <= 1'b1;
		@(posedge ref_clk);
		start_conv <= 1'b0;
		trk = 0;
		cv = 0;
		lat = 0;
		for (int i = 0; i < 400; i++) begin
			#1;
			if (converting === 1'b1) cv++;
			else if (cv == 0) lat++;
			else break;
			if (tracking === 1'b1) trk++;
			@(posedge ref_clk);
		end
	endtask : conv
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end
	initial begin
		repeat (8) @(posedge ref_clk);
		nrst <= 1'b1;
		rc(ADCSQ_TRACK_CFG_ADDR, 8'hff);
		rc(ADCSQ_LIMIT_FLAGS_ADDR, 8'h00);
		wr(ADCSQ_POINTER_ADDR, ADCSQ_TEMP_LTL_IADDR);
		rc(ADCSQ_WINDOW_ADDR, 8'h00);
		wr(ADCSQ_WINDOW_ADDR, 8'ha5);
		rc(ADCSQ_WINDOW_ADDR, 8'ha5);
		chk(temp_low_limit_lo, 8'ha5);
		for (int i = 0; i < 4; i++) begin
			wr(ADCSQ_POINTER_ADDR, 8'(i));
			rc(ADCSQ_WINDOW_ADDR, 8'h00);
			wr(ADCSQ_WINDOW_ADDR, 8'(((2*i + 9) << 4) | (2*i + 8)));
		end
		for (int s = 0; s < 8; s++) begin
			@(posedge ref_clk);
			slot_index <= 3'(s);
			#1 chk({4'h0, analog_input_mux}, 8'(s + 8));
		end
		rc(8'h10, 8'h00);
		chk({7'h00, sfr_hit}, 8'h00);
		wr(ADCSQ_POINTER_ADDR, 8'h10);
		rc(ADCSQ_WINDOW_ADDR, 8'h00);
		wr(ADCSQ_LIMIT_FLAGS_ADDR, 8'hff);
		rc(ADCSQ_LIMIT_FLAGS_ADDR, 8'h00);
		for (int m = 0; m < 4; m++) begin
			wr(ADCSQ_TRACK_CFG_ADDR, 8'(m << 2));
			chk({6'h00, tracking_mode_sel}, 8'(m));
			chk({7'h00, mode_reserved}, {7'h00, m == 0});
		end
		wr(ADCSQ_SAR_CFG_ADDR, 8'h00);
		wr(ADCSQ_CONTROL_ADDR, 8'h80);
		chk({7'h00, adc_powered}, 8'h01);
		chk({7'h00, sar_clk_tick}, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(ADCSQ_TRACK_CFG_ADDR, 8'(4 | k));
			conv();
			chn(trk, 2 << k);
			chn(cv, 2 + (2 << k) + 13 + 2);
			if (k == 0) lat0 = lat;
		end
		wr(ADCSQ_CONTROL_ADDR, 8'h00);
		chk({7'h00, adc_powered}, 8'h00);
		wr(ADCSQ_CONTROL_ADDR, 8'h40);
		chk({7'h00, adc_powered}, 8'h00);
		wr(ADCSQ_TRACK_CFG_ADDR, 8'h14);
		conv();
		chn(lat - lat0, 80);
		chn(cv, 19);
		#20 chk({7'h00, adc_powered}, 8'h00);
		wr(ADCSQ_CONTROL_ADDR, 8'hc0);
		chk({7'h00, adc_powered}, 8'h01);
		@(posedge ref_clk);
		high_limits <= {12'h200, 72'h0, 12'h100};
		low_limits <= {12'h100, 72'h0, 12'h200};
		res(3'h0, 12'h150);
		res(3'h7, 12'h050);
		chk(limit_flags, 8'h81);
		rc(ADCSQ_LIMIT_FLAGS_ADDR, 8'h81);
		res(3'h0, 12'h100);
		res(3'h7, 12'h150);
		chk(limit_flags, 8'h00);
		end_sim();
	end
endmodule : adcsq_top_test
`default_nettype wire
